//--- hw/actual_value_pkg.sv
/*
 * Constants of the actual value readout bank: parameter numbers, subindices,
 * input-word field layout, scaling shift and reset values.
 * Assumes a single 25 MHz drive clock and a synchronous active-high reset.
 */
// Contract
// - position signed 32-bit at number 1100 sub 0
// - position scaled to fieldbus unit, may overflow
// - velocity signed 32-bit read-only at 1101, scaled
// - current in thousandths of rated, 1102 read-only
// - rising sample edge latches position, 1110 sub 0
// - falling sample edge latches position, 1110 sub 1
// - configuration picks ninth or tenth base input
// - input word at 1141, bit0 zero, bit31 reserved
// - base inputs zero to eleven on bits 1-12
// - limit switches negative bit 7, positive bit 8
// - bits 11,12 optional inputs replacing outputs 3,4
// - expansion slot one bits 13-20, slot two 23-30
// - analogue one and two as digital, bits 21,22
package actual_value_pkg;

    // parameter numbers of the bank
    localparam logic [15:0] PNUM_POSITION     = 16'h044C; // 1100
    localparam logic [15:0] PNUM_VELOCITY     = 16'h044D; // 1101
    localparam logic [15:0] PNUM_CURRENT      = 16'h044E; // 1102
    localparam logic [15:0] PNUM_CAPTURE      = 16'h0456; // 1110
    localparam logic [15:0] PNUM_INPUTS       = 16'h0475; // 1141

    // subindices
    localparam logic [7:0]  SUB_MAIN          = 8'h00;
    localparam logic [7:0]  SUB_CAPTURE_RISE  = 8'h00;
    localparam logic [7:0]  SUB_CAPTURE_FALL  = 8'h01;

    // input word layout
    localparam int          BIT_ZERO          = 0;
    localparam int          BIT_BASE_LO       = 1;
    localparam int          BIT_OPT_DOUT_LO   = 11;
    localparam int          BIT_SLOT1_LO      = 13;
    localparam int          BIT_ANALOG_LO     = 21;
    localparam int          BIT_SLOT2_LO      = 23;
    localparam int          BIT_RESERVED      = 31;

    // pin bundle layout entering the synchroniser
    localparam int          BASE_COUNT        = 12;
    localparam int          SLOT_COUNT        = 8;
    localparam int          ANALOG_COUNT      = 2;
    localparam int          PIN_COUNT         = BASE_COUNT + 2 * SLOT_COUNT + ANALOG_COUNT;
    localparam int          PIN_SLOT1_LO      = 12;
    localparam int          PIN_SLOT2_LO      = 20;
    localparam int          PIN_ANALOG_LO     = 28;
    localparam int          CAPTURE_A_INDEX   = 8;   // ninth base input
    localparam int          CAPTURE_B_INDEX   = 9;   // tenth base input

    // scaling: fixed point factor with this many fraction bits
    localparam int          SCALE_SHIFT       = 16;
    localparam int          RAW_WIDTH         = 48;
    localparam int          FACTOR_WIDTH      = 24;

    // reset values
    localparam logic [31:0] RESET_WORD        = 32'h0000_0000;

endpackage : actual_value_pkg

//--- hw/pin_input_filter.sv
/*
 * Three-flop synchroniser for a bundle of pin inputs. A change is taken
 * once the second and third flop agree.
 * Assumes pins are asynchronous to i_clock; reset is synchronous.
 */
`timescale 1ns/1ps
module pin_input_filter #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    // raw pins
    input  wire logic [WIDTH-1:0] i_pins,
    // filtered levels
    output logic      [WIDTH-1:0] o_levels
);

    // complete state of the filter
    typedef struct packed {
        logic [WIDTH-1:0] first;  // read only by second
        logic [WIDTH-1:0] second;
        logic [WIDTH-1:0] third;
        logic [WIDTH-1:0] level;
    } filter_s;

    filter_s state_q;  // registered state
    filter_s state_d;  // next state

    // next state: shift, then accept bits where second and third agree
    always_comb begin
        state_d        = state_q;
        state_d.first  = i_pins;
        state_d.second = state_q.first;
        state_d.third  = state_q.second;
        for (int i = 0; i < WIDTH; i++) begin
            // agreement of the later two stages
            if (state_q.second[i] == state_q.third[i]) begin
                state_d.level[i] = state_q.third[i];
            end
        end
    end

    // register with synchronous reset
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_levels = state_q.level;

endmodule : pin_input_filter

//--- hw/drive_actual_value_readout.sv
/*
 * Actual value readout bank: scaled position, velocity and current,
 * edge-captured positions and the packed digital input word, answered by
 * parameter number and subindex.
 * Assumes control values arrive synchronous to i_clock, pins asynchronous.
 */
`timescale 1ns/1ps
module drive_actual_value_readout (
    // clock and reset
    input  wire logic                                        i_clock,
    input  wire logic                                        i_rst,
    // parameter access request
    input  wire logic                                        i_req_valid,
    input  wire logic                                        i_req_write,
    input  wire logic [15:0]                                 i_parameter_number,
    input  wire logic [7:0]                                  i_subindex,
    input  wire logic [31:0]                                 i_write_data,
    // parameter access answer
    output logic                                             o_ack,
    output logic                                             o_error,
    output logic      [31:0]                                 o_read_data,
    // internal control values
    input  wire logic signed [actual_value_pkg::RAW_WIDTH-1:0] i_position_raw,
    input  wire logic signed [actual_value_pkg::RAW_WIDTH-1:0] i_velocity_raw,
    input  wire logic signed [actual_value_pkg::RAW_WIDTH-1:0] i_current_raw,
    // unit scaling factors, fixed point
    input  wire logic signed [actual_value_pkg::FACTOR_WIDTH-1:0] i_position_factor,
    input  wire logic signed [actual_value_pkg::FACTOR_WIDTH-1:0] i_velocity_factor,
    input  wire logic signed [actual_value_pkg::FACTOR_WIDTH-1:0] i_current_factor,
    // configuration
    input  wire logic                                        i_capture_select,
    input  wire logic [1:0]                                  i_dout_as_input,
    input  wire logic [1:0]                                  i_analog_as_digital,
    input  wire logic [1:0]                                  i_slot_present,
    // pins
    input  wire logic [actual_value_pkg::BASE_COUNT-1:0]     i_base_inputs,
    input  wire logic [actual_value_pkg::SLOT_COUNT-1:0]     i_slot1_inputs,
    input  wire logic [actual_value_pkg::SLOT_COUNT-1:0]     i_slot2_inputs,
    input  wire logic [actual_value_pkg::ANALOG_COUNT-1:0]   i_analog_inputs
);
    import actual_value_pkg::*;

    // fixed point scaling; upper bits of the product are dropped on purpose
    function automatic logic signed [31:0] scale_value(
        input logic signed [RAW_WIDTH-1:0]    raw,
        input logic signed [FACTOR_WIDTH-1:0] factor
    );
        logic signed [RAW_WIDTH+FACTOR_WIDTH-1:0] product;
        product     = raw * factor;
        scale_value = 32'(product >>> SCALE_SHIFT);
    endfunction : scale_value

    // complete state of the bank
    typedef struct packed {
        logic [31:0] position_offset; // software preset of position
        logic        sample_prev;     // last sample level
        logic [31:0] capture_rise;    // position at rising edge
        logic [31:0] capture_fall;    // position at falling edge
        logic        ack;             // answer strobe
        logic        error;           // answer refused
        logic [31:0] read_data;       // answer data
    } bank_s;

    bank_s state_q;  // registered state
    bank_s state_d;  // next state

    // synchronised pins
    logic [PIN_COUNT-1:0] pin_levels;
    // derived values
    logic [31:0]          position_now;   // reported position
    logic [31:0]          velocity_now;   // reported velocity
    logic [31:0]          current_now;    // reported current
    logic                 sample_now;     // selected sampling level
    logic [31:0]          input_word;     // packed inputs
    logic                 hit_position;   // decode hits
    logic                 hit_velocity;
    logic                 hit_current;
    logic                 hit_rise;
    logic                 hit_fall;
    logic                 hit_inputs;

    // pin synchroniser for every input pin
    pin_input_filter #(
        .WIDTH (PIN_COUNT)
    ) u_pin_filter (
        .i_clock  (i_clock),
        .i_rst    (i_rst),
        .i_pins   ({i_analog_inputs, i_slot2_inputs, i_slot1_inputs, i_base_inputs}),
        .o_levels (pin_levels)
    );

    // scaled actual values
    always_comb begin
        position_now = scale_value(i_position_raw, i_position_factor) + state_q.position_offset;
        velocity_now = scale_value(i_velocity_raw, i_velocity_factor);
        current_now  = scale_value(i_current_raw, i_current_factor);
    end

    // sampling input choice
    always_comb begin
        sample_now = i_capture_select ? pin_levels[CAPTURE_B_INDEX] : pin_levels[CAPTURE_A_INDEX];
    end

    // packed input word, absent inputs forced low
    always_comb begin
        input_word                    = RESET_WORD;
        input_word[BIT_ZERO]          = 1'b0;
        input_word[BIT_RESERVED]      = 1'b0;
        // base inputs 0..9 always fitted, in order; includes limits
        input_word[BIT_BASE_LO +: 10] = pin_levels[9:0];
        // base inputs 10,11 exist only when the output pins act as inputs
        input_word[BIT_OPT_DOUT_LO]   = pin_levels[10] & i_dout_as_input[0];
        input_word[BIT_OPT_DOUT_LO+1] = pin_levels[11] & i_dout_as_input[1];
        // expansion modules
        input_word[BIT_SLOT1_LO +: SLOT_COUNT] = pin_levels[PIN_SLOT1_LO +: SLOT_COUNT]
                                                 & {SLOT_COUNT{i_slot_present[0]}};
        input_word[BIT_SLOT2_LO +: SLOT_COUNT] = pin_levels[PIN_SLOT2_LO +: SLOT_COUNT]
                                                 & {SLOT_COUNT{i_slot_present[1]}};
        // analogue inputs used as digital
        input_word[BIT_ANALOG_LO +: ANALOG_COUNT] = pin_levels[PIN_ANALOG_LO +: ANALOG_COUNT]
                                                    & i_analog_as_digital;
    end

    // address decode by parameter number and subindex
    always_comb begin
        hit_position = (i_parameter_number == PNUM_POSITION) && (i_subindex == SUB_MAIN);
        hit_velocity = (i_parameter_number == PNUM_VELOCITY) && (i_subindex == SUB_MAIN);
        hit_current  = (i_parameter_number == PNUM_CURRENT)  && (i_subindex == SUB_MAIN);
        hit_rise     = (i_parameter_number == PNUM_CAPTURE)  && (i_subindex == SUB_CAPTURE_RISE);
        hit_fall     = (i_parameter_number == PNUM_CAPTURE)  && (i_subindex == SUB_CAPTURE_FALL);
        hit_inputs   = (i_parameter_number == PNUM_INPUTS)   && (i_subindex == SUB_MAIN);
    end

    // next state
    always_comb begin
        state_d             = state_q;
        state_d.ack         = 1'b0;
        state_d.error       = 1'b0;
        state_d.sample_prev = sample_now;
        // edge capture of the reported position
        if (sample_now && !state_q.sample_prev) begin
            state_d.capture_rise = position_now;
        end
        if (!sample_now && state_q.sample_prev) begin
            state_d.capture_fall = position_now;
        end
        // parameter access, answered next cycle
        if (i_req_valid) begin
            state_d.ack       = 1'b1;
            state_d.read_data = RESET_WORD;
            if (i_req_write) begin
                // only the position accepts a write: it presets the value
                if (hit_position) begin
                    state_d.position_offset = i_write_data
                        - scale_value(i_position_raw, i_position_factor);
                end else begin
                    state_d.error = 1'b1;  // read-only or unknown
                end
            end else begin
                unique case (1'b1)
                    hit_position: state_d.read_data = position_now;
                    hit_velocity: state_d.read_data = velocity_now;
                    hit_current:  state_d.read_data = current_now;
                    hit_rise:     state_d.read_data = state_q.capture_rise;
                    hit_fall:     state_d.read_data = state_q.capture_fall;
                    hit_inputs:   state_d.read_data = input_word;
                    default:      state_d.error     = 1'b1;                 // unmapped
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // answer outputs straight from flops
    assign o_ack       = state_q.ack;
    assign o_error     = state_q.error;
    assign o_read_data = state_q.read_data;

    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // every request answered exactly one cycle later
    a_ack_one_cycle: assert property (i_req_valid |=> o_ack ##1 (o_ack == $past(i_req_valid)))
        else $error("request not answered one cycle later");

    // position read returns the reported position
    a_position_read: assert property (
        (i_req_valid && !i_req_write && hit_position) |=> (o_read_data == $past(position_now) && !o_error))
        else $error("position read mismatch");

    // position write presets the reported value, seen while motion stands still
    a_position_preset: assert property (
        (i_req_valid && i_req_write && hit_position) |=>
        (($stable(i_position_raw) && $stable(i_position_factor))
         |-> position_now == $past(i_write_data)))
        else $error("position preset not applied");

    // velocity and current are read only
    a_readonly_write: assert property (
        (i_req_valid && i_req_write && (hit_velocity || hit_current || hit_rise || hit_fall || hit_inputs))
        |=> o_error)
        else $error("write to read-only value not refused");

    // current read returns scaled current
    a_current_read: assert property (
        (i_req_valid && !i_req_write && hit_current) |=> (o_read_data == $past(current_now)))
        else $error("current read mismatch");

    // rising edge of the selected input latches position
    a_rise_capture: assert property (
        (sample_now && !state_q.sample_prev) |=> (state_q.capture_rise == $past(position_now)))
        else $error("rising capture missed");

    // falling edge latches into the second slot, rise untouched
    a_fall_capture: assert property (
        (!sample_now && state_q.sample_prev) |=>
        (state_q.capture_fall == $past(position_now) && $stable(state_q.capture_rise)))
        else $error("falling capture missed");

    // sampling input follows the configured pin once it has settled
    a_sample_select: assert property (
        $stable(i_base_inputs[CAPTURE_B_INDEX:CAPTURE_A_INDEX]) [*6] |->
        sample_now == (i_capture_select ? i_base_inputs[CAPTURE_B_INDEX]
                                        : i_base_inputs[CAPTURE_A_INDEX]))
        else $error("wrong sampling input");

    // input word edges read zero
    a_word_edges: assert property (
        (i_req_valid && !i_req_write && hit_inputs) |=> (o_read_data[BIT_ZERO] == 1'b0
        && o_read_data[BIT_RESERVED] == 1'b0))
        else $error("input word edge bits not zero");

    // base inputs and limit switches in order once the pins have settled
    a_base_map: assert property (
        $stable(i_base_inputs[9:0]) [*6] |-> input_word[10:1] == i_base_inputs[9:0])
        else $error("base inputs misplaced");

    // absent expansion slot reads zero
    a_absent_zero: assert property (
        (!i_slot_present[1] && !i_analog_as_digital[0]) |-> (input_word[30:23] == 8'h00 && !input_word[21]))
        else $error("absent inputs not zero");

    // velocity read returns scaled velocity
    a_velocity_read: assert property (
        (i_req_valid && !i_req_write && hit_velocity) |=> (o_read_data == $past(velocity_now) && !o_error))
        else $error("velocity read mismatch");

    // input word read returns the packed word
    a_inputs_read: assert property (
        (i_req_valid && !i_req_write && hit_inputs) |=> (o_read_data == $past(input_word)))
        else $error("input word read mismatch");

    // refused answers carry no data
    a_refused_zero: assert property (
        (o_ack && o_error) |-> (o_read_data == 32'h0000_0000))
        else $error("refused answer carries data");

    // optional inputs instead of outputs follow their pins when enabled
    a_opt_dout: assert property (
        $stable(i_base_inputs[11:10]) [*6] |->
        input_word[12:11] == (i_base_inputs[11:10] & i_dout_as_input))
        else $error("optional inputs misplaced");

    // first expansion slot follows its pins when fitted
    a_slot_map: assert property (
        $stable(i_slot1_inputs) [*6] |->
        input_word[20:13] == (i_slot1_inputs & {SLOT_COUNT{i_slot_present[0]}}))
        else $error("slot one inputs misplaced");

    // analogue inputs used as digital follow their pins
    a_analog_map: assert property (
        $stable(i_analog_inputs) [*6] |->
        input_word[22:21] == (i_analog_inputs & i_analog_as_digital))
        else $error("analogue inputs misplaced");

endmodule : drive_actual_value_readout

//--- test/fieldbus_master_model.sv
/*
 * Fieldbus master model: queues parameter requests, sends one per cycle,
 * collects answers in arrival order.
 * Assumes the readout bank answers one cycle after each taken request.
 */
`timescale 1ns/1ps
module fieldbus_master_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // answer from the bank
    input  wire logic        i_ack,
    input  wire logic        i_error,
    input  wire logic [31:0] i_read_data,
    // request to the bank
    output logic             o_req_valid,
    output logic             o_req_write,
    output logic      [15:0] o_parameter_number,
    output logic      [7:0]  o_subindex,
    output logic      [31:0] o_write_data
);
    logic [56:0] req_queue[$];  // pending {write, number, sub, data}
    logic [32:0] resp_queue[$]; // answers {error, data}
    // one request per cycle; idle number and data fields scramble so nothing stale looks valid
    always @(posedge i_clock) begin
        if (i_ack) begin
            resp_queue.push_back({i_error, i_read_data});
        end
        if (i_rst) begin
            {o_req_valid, o_req_write, o_parameter_number, o_subindex, o_write_data} <= '0;
        end else if (req_queue.size() > 0) begin
            {o_req_write, o_parameter_number, o_subindex, o_write_data} <= req_queue.pop_front();
            o_req_valid <= 1'b1;
        end else begin
            o_req_valid        <= 1'b0;
            o_parameter_number <= ~o_parameter_number;
            o_write_data       <= ~o_write_data;
        end
    end
endmodule : fieldbus_master_model

//--- test/drive_actual_value_readout_tb.sv
/*
 * Self-checking bench of the actual value readout bank: scaling, presets,
 * edge captures, input word packing and refused accesses.
 * Assumes the master model sits on the request port; 25 MHz clock.
 */
`timescale 1ns/1ps
module drive_actual_value_readout_tb;
    import actual_value_pkg::*;
    logic i_clock, i_rst, i_req_valid, i_req_write, o_ack, o_error, i_capture_select;
    logic [15:0] i_parameter_number;
    logic [7:0] i_subindex, i_slot1_inputs, i_slot2_inputs;
    logic [31:0] i_write_data, o_read_data, lfsr, pre, dv;
    logic signed [47:0] i_position_raw, i_velocity_raw, i_current_raw;
    logic signed [23:0] i_position_factor, i_velocity_factor, i_current_factor;
    logic [1:0] i_dout_as_input, i_analog_as_digital, i_slot_present, i_analog_inputs;
    logic [11:0] i_base_inputs;
    logic [24:0] bad [10];
    int error_cnt, check_count, cyc;
    // design and master model
    drive_actual_value_readout i_drive_actual_value_readout (.*);
    fieldbus_master_model i_fieldbus_master_model (.i_clock(i_clock), .i_rst(i_rst), .i_ack(o_ack),
        .i_error(o_error), .i_read_data(o_read_data), .o_req_valid(i_req_valid), .o_req_write(i_req_write),
        .o_parameter_number(i_parameter_number), .o_subindex(i_subindex), .o_write_data(i_write_data));
    // clock and hang guard
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    // galois lfsr for repeatable stimulus
    function logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
        return lfsr;
    endfunction : rnd
    function automatic logic [31:0] scaled(input logic signed [47:0] r, input logic signed [23:0] f);
        logic signed [71:0] p;
        p = r * f;
        return p[47:16];
    endfunction : scaled
    // expected input word from pins and fit-out
    function automatic logic [31:0] word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[10:1] = i_base_inputs[9:0];
        w[12:11] = i_base_inputs[11:10] & i_dout_as_input;
        w[20:13] = i_slot_present[0] ? i_slot1_inputs : 8'h00;
        w[22:21] = i_analog_inputs & i_analog_as_digital;
        w[30:23] = i_slot_present[1] ? i_slot2_inputs : 8'h00;
        return w;
    endfunction : word
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR time=%0t got=%h expected=%h", $time, got, exp);
        end
    endtask : check
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clock);
    endtask : cycles
    task automatic send(input logic w, input logic [15:0] pn, input logic [7:0] sb, input logic [31:0] d);
        i_fieldbus_master_model.req_queue.push_back({w, pn, sb, d});
    endtask : send
    // wait bounded for the next answer and compare it
    task automatic collect(input logic [32:0] exp);
        int n;
        for (n = 0; n < 20 && i_fieldbus_master_model.resp_queue.size() == 0; n++) begin
            @(posedge i_clock);
            #1;
        end
        if (i_fieldbus_master_model.resp_queue.size() == 0) check(33'h1_FFFF_FFFF, exp);
        else check(i_fieldbus_master_model.resp_queue.pop_front(), exp);
    endtask : collect
    task automatic rd(input logic [15:0] pn, input logic [7:0] sb, input logic [31:0] exp);
        send(1'b0, pn, sb, rnd());
        collect({1'b0, exp});
    endtask : rd
    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        lfsr = 32'h0001_599B; // 88475
        {error_cnt, check_count} = '0;
        {i_position_raw, i_velocity_raw, i_current_raw, i_capture_select, i_base_inputs} = '0;
        {i_slot1_inputs, i_slot2_inputs, i_analog_inputs, i_dout_as_input} = '0;
        {i_analog_as_digital, i_slot_present} = '0;
        {i_position_factor, i_velocity_factor, i_current_factor} = {3{24'h01_0000}};
        bad = '{{1'b1, PNUM_VELOCITY, SUB_MAIN}, {1'b1, PNUM_CURRENT, SUB_MAIN}, {1'b1, PNUM_INPUTS, SUB_MAIN},
                {1'b1, PNUM_CAPTURE, SUB_CAPTURE_RISE}, {1'b1, PNUM_CAPTURE, SUB_CAPTURE_FALL},
                {1'b1, PNUM_POSITION, 8'h01}, {1'b0, PNUM_POSITION, 8'h01}, {1'b0, 16'h044F, SUB_MAIN},
                {1'b0, PNUM_CAPTURE, 8'h02}, {1'b0, PNUM_INPUTS, 8'h01}};
        i_rst = 1'b1;
        cycles(10);
        i_rst <= 1'b0;
        rd(PNUM_CAPTURE, SUB_CAPTURE_FALL, 32'h0000_0000);
        // random scaling, three reads back to back; first pass overflows on purpose
        for (int i = 0; i < 12; i++) begin
            @(posedge i_clock);
            i_position_raw <= (i == 0) ? 48'h8000_0000_0000 : 48'({rnd(), rnd()});
            i_velocity_raw <= 48'({rnd(), rnd()});
            i_current_raw <= 48'({rnd(), rnd()});
            i_position_factor <= (i == 0) ? 24'h7F_FFFF : 24'(rnd());
            i_velocity_factor <= 24'(rnd());
            i_current_factor <= 24'(rnd());
            cycles(3);
            send(1'b0, PNUM_POSITION, SUB_MAIN, rnd());
            send(1'b0, PNUM_VELOCITY, SUB_MAIN, rnd());
            send(1'b0, PNUM_CURRENT, SUB_MAIN, rnd());
            collect({1'b0, scaled(i_position_raw, i_position_factor)});
            collect({1'b0, scaled(i_velocity_raw, i_velocity_factor)});
            collect({1'b0, scaled(i_current_raw, i_current_factor)});
        end
        // input word: all absent, all present, then random fit-outs
        for (int i = 0; i < 16; i++) begin
            @(posedge i_clock);
            {i_base_inputs, i_slot1_inputs, i_slot2_inputs, i_analog_inputs} <= 30'((i < 2) ? '1 : {rnd(), rnd()});
            {i_dout_as_input, i_analog_as_digital, i_slot_present} <= 6'((i == 0) ? '0 : (i == 1) ? '1 : rnd());
            cycles(6);
            rd(PNUM_INPUTS, SUB_MAIN, word());
        end
        // edge captures for each sampling input; the other input must not capture
        for (int s = 0; s < 2; s++) begin
            @(posedge i_clock);
            i_capture_select <= s[0];
            i_base_inputs <= 12'h000;
            i_position_raw <= 48'({rnd(), rnd()});
            cycles(8);
            pre = scaled(i_position_raw, i_position_factor);
            i_base_inputs[8 + s] <= 1'b1;
            cycles(8);
            i_position_raw <= 48'({rnd(), rnd()});
            cycles(8);
            dv = scaled(i_position_raw, i_position_factor);
            i_base_inputs[8 + s] <= 1'b0;
            cycles(8);
            i_position_raw <= 48'({rnd(), rnd()});
            i_base_inputs[9 - s] <= 1'b1;
            cycles(8);
            rd(PNUM_CAPTURE, SUB_CAPTURE_RISE, pre);
            rd(PNUM_CAPTURE, SUB_CAPTURE_FALL, dv);
        end
        // writes to read-only places and unmapped accesses are refused
        foreach (bad[k]) begin
            send(bad[k][24], bad[k][23:8], bad[k][7:0], rnd());
            collect({1'b1, 32'h0000_0000});
        end
        // position preset, read straight after, then follows motion
        dv = rnd();
        pre = scaled(i_position_raw, i_position_factor);
        send(1'b1, PNUM_POSITION, SUB_MAIN, dv);
        send(1'b0, PNUM_POSITION, SUB_MAIN, rnd());
        collect({1'b0, 32'h0000_0000});
        collect({1'b0, dv});
        @(posedge i_clock);
        i_position_raw <= 48'({rnd(), rnd()});
        cycles(3);
        rd(PNUM_POSITION, SUB_MAIN, dv + scaled(i_position_raw, i_position_factor) - pre);
        // reset in mid-run clears preset and captures
        @(posedge i_clock);
        i_rst <= 1'b1;
        cycles(2);
        i_rst <= 1'b0;
        cycles(2);
        rd(PNUM_POSITION, SUB_MAIN, scaled(i_position_raw, i_position_factor));
        rd(PNUM_CAPTURE, SUB_CAPTURE_RISE, 32'h0000_0000);
        finish_test();
    end
endmodule : drive_actual_value_readout_tb
